// *** bench/mts_conv_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module mts_conv_model #(
    parameter logic [15:0] IN_VAL  = 16'h0500,
    parameter logic [15:0] OFF_VAL = 16'h0020
) (
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        conv_start,
    input  wire logic        conv_offset_step,
    input  wire logic        slow,
    output logic             conv_done,
    output logic [15:0]      conv_data
);
    logic [2:0] cnt;
    logic       step;
    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            cnt       <= 3'h0;
            step      <= 1'b0;
            conv_done <= 1'b0;
            conv_data <= 16'ha5a5;
        end else begin
            conv_done <= 1'b0;
            // Data mean nothing away from conv_done, so keep them moving
            conv_data <= ~conv_data;
            if (cnt == 3'h1) begin
                conv_done <= 1'b1;
                // offset step sees only the isolated offset
                conv_data <= step ? OFF_VAL : IN_VAL;
            end
            if (cnt != 3'h0)
                cnt <= cnt - 3'h1;
            else if (conv_start) begin
                cnt  <= slow ? 3'h6 : 3'h1;
                step <= conv_offset_step;
            end
        end
    end
endmodule
`default_nettype wire

// *** bench/mts_sequencer_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "mts_defs.vh"
module mts_sequencer_sva (
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire logic [3:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        conv_start,
    input wire logic        conv_offset_step,
    input wire logic        current_source_on,
    input wire logic        busy,
    input wire logic        scan_advance
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    wire arm_req = wr && addr == `MTS_A_CMD && wdata[`MTS_CMD_ARM];

    AST_START_ONE_CYCLE: assert property (conv_start |=> !conv_start)
        else $error("conversion start longer than one cycle");
    AST_STEP_HELD: assert property (conv_start |=> $stable(conv_offset_step) [*2])
        else $error("step kind changed during conversion");
    AST_START_NEEDS_RUN: assert property (conv_start |-> busy && $past(busy))
        else $error("conversion started outside a run");
    AST_BUSY_ON_ARM: assert property ($rose(busy) |-> $past(arm_req))
        else $error("busy rose without an arm command");
    AST_OFFSET_CURRENT_OFF: assert property (conv_offset_step |-> !current_source_on)
        else $error("current source on during offset step");
    AST_CURRENT_IN_RUN: assert property (current_source_on |-> busy)
        else $error("current source on while idle");
    AST_SCAN_ONE_CYCLE: assert property (scan_advance |=> !scan_advance)
        else $error("scan advance longer than one cycle");
    AST_SCAN_IN_RUN: assert property (scan_advance |-> $past(busy))
        else $error("scan advance outside a run");

    cover property (conv_start && conv_offset_step);
    cover property (scan_advance);
    cover property ($fell(busy));
endmodule

bind mts_sequencer mts_sequencer_sva u_sva (
    .ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .conv_start(conv_start), .conv_offset_step(conv_offset_step),
    .current_source_on(current_source_on), .busy(busy), .scan_advance(scan_advance));
`default_nettype wire

// *** bench/mts_sequencer_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "mts_defs.vh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module mts_sequencer_tb;
    logic        ref_clk = 1'b0;
    logic        resetn  = 1'b0;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic        external_edge_source     = 1'b1;
    logic        rng     = 1'b0;
    logic        slow    = 1'b0;
    logic [3:0]  addr    = 4'h0;
    logic [15:0] wdata   = 16'h0000;
    logic [7:0]  bp      = 8'hff;
    logic [15:0] d;
    wire  [15:0] rdata, cdata;
    wire         cstart, cstep, cur, cdone, busy, scan;
    int          failures = 0;
    int          total_checks = 0;
    int          n_conv, n_off, n_cur, n_scan;
    localparam logic [15:0] IN_V  = 16'h0500;
    localparam logic [15:0] OFF_V = 16'h0020;
    localparam logic [3:0]  LVL   = 4'h8;

    always #50 ref_clk = ~ref_clk;
    mts_sequencer DUT (.ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .ext_trig_in(external_edge_source), .backplane_trigger_lines(bp),
        .range_change(rng), .conv_start(cstart), .conv_offset_step(cstep),
        .current_source_on(cur), .conv_done(cdone), .conv_data(cdata), .busy(busy),
        .scan_advance(scan));
    mts_conv_model #(.IN_VAL(IN_V), .OFF_VAL(OFF_V)) u_conv (.ref_clk(ref_clk),
        .resetn(resetn), .conv_start(cstart), .conv_offset_step(cstep), .slow(slow),
        .conv_done(cdone), .conv_data(cdata));

    always @(posedge ref_clk) begin
        if (cstart === 1'b1) begin
            n_conv++;
            if (cstep === 1'b1) n_off++;
            else if (cur === 1'b1) n_cur++;
        end
        if (scan === 1'b1) n_scan++;
    end

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic chk_reg(input logic [3:0] a, input logic [15:0] e,
                           input logic [15:0] m = 16'hffff);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
        `CHK("register", e, d & m)
    endtask
    task automatic cmd(input int b);
        wr_reg(`MTS_A_CMD, 16'h0001 << b);
    endtask
    task automatic clr;
        n_conv = 0;
        n_off  = 0;
        n_cur  = 0;
        n_scan = 0;
    endtask
    task automatic wait_idle;
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 8000) begin
            @(posedge ref_clk);
            #1;
            k++;
        end
        `CHK("busy", 1'b0, busy)
    endtask
    task automatic go;
        clr;
        cmd(`MTS_CMD_ARM);
        wait_idle;
    endtask
    // Falling edges on the masked backplane lines, and on ext when e is low
    task automatic pulse(input logic [7:0] m, input logic e);
        @(posedge ref_clk);
        bp  <= ~m;
        external_edge_source <= e;
        @(posedge ref_clk);
        bp  <= 8'hff;
        external_edge_source <= 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    task automatic endt(input string n);
        $display("test %s done", n);
    endtask

    task automatic t_reset;
        chk_reg(`MTS_A_CTRL, {5'h00, `MTS_CTRL_RST});
        chk_reg(`MTS_A_TRIGSRC, {13'h0000, `MTS_TS_INT});
        chk_reg(`MTS_A_TRIGCNT, 16'h0001);
        chk_reg(`MTS_A_SAMPCNT, 16'h0001);
        chk_reg(`MTS_A_STATUS, 16'h0000);
        chk_reg(4'hf, 16'h0000);
        endt("reset");
    endtask
    task automatic t_zero;
        go;
        `CHK("conversions", 2, n_conv)
        `CHK("offset steps", 1, n_off)
        chk_reg(`MTS_A_DATA, IN_V - OFF_V);
        cmd(`MTS_CMD_RDPOP);
        wr_reg(`MTS_A_CTRL, 16'h0000);
        rng <= 1'b1;
        go;
        rng <= 1'b0;
        `CHK("conversions", 1, n_conv)
        `CHK("offset steps", 0, n_off)
        chk_reg(`MTS_A_DATA, IN_V);
        cmd(`MTS_CMD_RDPOP);
        endt("zero offset");
    endtask
    task automatic t_once;
        wr_reg(`MTS_A_CTRL, {14'h0000, `MTS_ZO_ONCE});
        go;
        `CHK("conversions", 2, n_conv)
        chk_reg(`MTS_A_STATUS, 16'h0008, 16'h0008);
        chk_reg(`MTS_A_DATA, IN_V - OFF_V);
        cmd(`MTS_CMD_RDPOP);
        go;
        `CHK("conversions", 1, n_conv)
        chk_reg(`MTS_A_DATA, IN_V - OFF_V);
        cmd(`MTS_CMD_RDPOP);
        endt("once");
    endtask
    task automatic t_comp;
        slow <= 1'b1;
        wr_reg(`MTS_A_CTRL, 16'h0015);
        go;
        `CHK("conversions", 2, n_conv)
        `CHK("current on steps", 1, n_cur)
        cmd(`MTS_CMD_RDPOP);
        slow <= 1'b0;
        endt("compensation");
    endtask
    task automatic t_loops;
        wr_reg(`MTS_A_CTRL, 16'h0040);
        wr_reg(`MTS_A_TRIGCNT, 16'h0002);
        wr_reg(`MTS_A_SAMPCNT, 16'h0003);
        go;
        `CHK("conversions", 6, n_conv)
        `CHK("scan passes", 2, n_scan)
        chk_reg(LVL, 16'h0006);
        repeat (6) cmd(`MTS_CMD_RDPOP);
        chk_reg(LVL, 16'h0000);
        wr_reg(`MTS_A_TRIGCNT, 16'h0001);
        wr_reg(`MTS_A_SAMPCNT, 16'h0001);
        endt("loops");
    endtask
    task automatic t_src;
        logic [2:0] s [3] = '{`MTS_TS_EXT, `MTS_TS_HOLD, `MTS_TS_BUS};
        for (int i = 0; i < 3; i++) begin
            wr_reg(`MTS_A_TRIGSRC, {13'h0000, s[i]});
            clr;
            pulse(8'h00, 1'b0);
            cmd(`MTS_CMD_ARM);
            pulse(8'hff, s[i] == `MTS_TS_EXT);
            if (s[i] != `MTS_TS_BUS) cmd(`MTS_CMD_BUSTRG);
            `CHK("early conversions", 0, n_conv)
            case (s[i])
                `MTS_TS_EXT: pulse(8'h00, 1'b0);
                `MTS_TS_HOLD: cmd(`MTS_CMD_SWTRG);
                default: cmd(`MTS_CMD_BUSTRG);
            endcase
            wait_idle;
            `CHK("conversions", 1, n_conv)
            cmd(`MTS_CMD_RDPOP);
        end
        endt("sources");
    endtask
    task automatic t_lines;
        for (int i = 0; i < 8; i++) begin
            wr_reg(`MTS_A_CTRL, 16'(i) << 8);
            wr_reg(`MTS_A_TRIGSRC, {13'h0000, `MTS_TS_BP});
            clr;
            cmd(`MTS_CMD_ARM);
            pulse(8'h01 << ((i + 1) % 8), 1'b0);
            `CHK("early conversions", 0, n_conv)
            pulse(8'h01 << i, 1'b1);
            wait_idle;
            `CHK("conversions", 1, n_conv)
            cmd(`MTS_CMD_RDPOP);
        end
        endt("backplane");
    endtask
    task automatic t_conf;
        wr_reg(`MTS_A_CTRL, 16'h0004);
        wr_reg(`MTS_A_TRIGSRC, {13'h0000, `MTS_TS_EXT});
        wr_reg(`MTS_A_TRIGCNT, 16'h0005);
        cmd(`MTS_CMD_CONF);
        chk_reg(`MTS_A_CTRL, 16'h0001);
        chk_reg(`MTS_A_TRIGSRC, {13'h0000, `MTS_TS_INT});
        chk_reg(`MTS_A_TRIGCNT, 16'h0001);
        endt("configure");
    endtask
    task automatic t_max;
        wr_reg(`MTS_A_TRIGCNT, 16'hffff);
        wr_reg(`MTS_A_FILL, 16'h00ff);
        chk_reg(`MTS_A_STATUS, 16'h0004, 16'h0004);
        chk_reg(`MTS_A_TRIGCNT, 16'hffff);
        wr_reg(`MTS_A_FILL, 16'h0000);
        cmd(`MTS_CMD_ERRCLR);
        chk_reg(`MTS_A_STATUS, 16'h0000, 16'h0004);
        wr_reg(`MTS_A_TRIGCNT, 16'h0001);
        endt("max count");
    endtask
    task automatic t_buf;
        for (int j = 0; j < 2; j++) begin
            wr_reg(`MTS_A_CTRL, j ? 16'h0020 : 16'h0000);
            wr_reg(`MTS_A_SAMPCNT, j ? 16'h0201 : 16'h0101);
            go;
            chk_reg(LVL, j ? 16'h0200 : 16'h0100);
            chk_reg(`MTS_A_STATUS, 16'h0010, 16'h0010);
            repeat (j ? 512 : 256) cmd(`MTS_CMD_RDPOP);
            chk_reg(LVL, 16'h0000);
            cmd(`MTS_CMD_ERRCLR);
        end
        endt("buffer");
    endtask

    task automatic stop_test;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        t_reset;
        t_zero;
        t_once;
        t_comp;
        t_loops;
        t_src;
        t_lines;
        t_conf;
        t_max;
        t_buf;
        stop_test;
    end
    // The buffer test dominates, well under a third of this span
    initial begin
        #3000000;
        failures++;
        stop_test;
    end
endmodule
`default_nettype wire

// *** src/mts_defs.vh ***
`ifndef MTS_DEFS_VH
`define MTS_DEFS_VH
// Register offsets (word address on the plain port)
`define MTS_A_CTRL      4'h0
`define MTS_A_TRIGSRC   4'h1
`define MTS_A_TRIGCNT   4'h2
`define MTS_A_SAMPCNT   4'h3
`define MTS_A_CMD       4'h4
`define MTS_A_STATUS    4'h5
`define MTS_A_DATA      4'h6
`define MTS_A_FILL      4'h7
`define MTS_A_OFFSET    4'h8
// Zero-offset modes
`define MTS_ZO_OFF      2'h0
`define MTS_ZO_ON       2'h1
`define MTS_ZO_ONCE     2'h2
// Trigger sources
`define MTS_TS_BUS      3'h0
`define MTS_TS_EXT      3'h1
`define MTS_TS_HOLD     3'h2
`define MTS_TS_INT      3'h3
`define MTS_TS_BP       3'h4
// Function codes
`define MTS_FN_DCV      2'h0
`define MTS_FN_ACV      2'h1
`define MTS_FN_RES      2'h2
// Command bits in MTS_A_CMD
`define MTS_CMD_ARM     0
`define MTS_CMD_SWTRG   1
`define MTS_CMD_CONF    2
`define MTS_CMD_ABORT   3
`define MTS_CMD_BUSTRG  4
`define MTS_CMD_ERRCLR  5
`define MTS_CMD_RDPOP   6
// Control field positions
`define MTS_C_ZO_LO     0
`define MTS_C_ZO_HI     1
`define MTS_C_OC        2
`define MTS_C_FN_LO     3
`define MTS_C_FN_HI     4
`define MTS_C_AP10      5
`define MTS_C_SCAN      6
`define MTS_C_BPSEL_LO  8
`define MTS_C_BPSEL_HI  10
// Counts, sizes and the control reset value
`define MTS_CNT_ONE     24'h000001
`define MTS_CNT_MAX     24'hffffff
`define MTS_BUF_WORDS   10'h200
`define MTS_BUF_HALF    10'h100
`define MTS_CTRL_RST    11'h001
// Converter step kinds
`define MTS_STEP_INPUT  1'b0
`define MTS_STEP_OFFSET 1'b1
`endif

// *** src/mts_sequencer.v ***
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "mts_defs.vh"
module mts_sequencer (
    input  wire        ref_clk,
    input  wire        resetn,
    input  wire [3:0]  addr,
    input  wire [15:0] wdata,
    input  wire        wr,
    input  wire        rd,
    output reg  [15:0] rdata,
    input  wire        ext_trig_in,
    input  wire [7:0]  backplane_trigger_lines,
    input  wire        range_change,
    output reg         conv_start,
    output reg         conv_offset_step,
    output reg         current_source_on,
    input  wire        conv_done,
    input  wire [15:0] conv_data,
    output reg         busy,
    output reg         scan_advance
);
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_TRIG = 2'h2;
    localparam CV_IDLE = 2'h0;
    localparam CV_IN   = 2'h1;
    localparam CV_OFS  = 2'h2;

    reg [10:0] ctrl;
    reg [2:0]  trig_src;
    reg [23:0] trig_cnt;
    reg [23:0] samp_cnt;
    reg [1:0]  state;
    reg [1:0]  cv;
    reg [23:0] trig_done;
    reg [23:0] samp_done;
    reg        err_mem;
    reg        ext_prev;
    reg        once_valid;
    reg        force_ofs;
    reg [1:0]  fn_prev;
    reg [15:0] in_val;
    reg [15:0] stored_ofs;
    reg [15:0] buf_mem [0:511];
    reg [8:0]  wr_ptr;
    reg [8:0]  rd_ptr;
    reg [9:0]  fill;
    reg        overflow;

    wire [1:0] zo_mode = ctrl[`MTS_C_ZO_HI:`MTS_C_ZO_LO];
    wire       oc_en   = ctrl[`MTS_C_OC];
    wire [1:0] fn      = ctrl[`MTS_C_FN_HI:`MTS_C_FN_LO];
    wire [2:0] bp_sel  = ctrl[`MTS_C_BPSEL_HI:`MTS_C_BPSEL_LO];
    wire       cmd_wr  = wr && (addr == `MTS_A_CMD);
    wire       sw_trg  = cmd_wr && wdata[`MTS_CMD_SWTRG];
    wire       bus_trg = cmd_wr && wdata[`MTS_CMD_BUSTRG];
    wire       conf    = cmd_wr && wdata[`MTS_CMD_CONF];
    wire       pop     = cmd_wr && wdata[`MTS_CMD_RDPOP] && (fill != 10'h000);

    // Per-line falling edge on the backplane, one generate loop
    reg  [7:0] bp_prev;
    wire [7:0] bp_fall;
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_bp
            always @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    bp_prev[g] <= 1'b1;
                end else begin
                    bp_prev[g] <= backplane_trigger_lines[g];
                end
            end
            assign bp_fall[g] = bp_prev[g] & ~backplane_trigger_lines[g];
        end
    endgenerate

    reg trig_hit;
    always @* begin
        case (trig_src)
            `MTS_TS_BUS:  trig_hit = bus_trg;
            `MTS_TS_EXT:  trig_hit = ext_prev & ~ext_trig_in;
            `MTS_TS_HOLD: trig_hit = sw_trg;
            `MTS_TS_INT:  trig_hit = 1'b1;
            `MTS_TS_BP:   trig_hit = bp_fall[bp_sel];
            default:      trig_hit = 1'b0;
        endcase
    end

    // Buffer capacity depends on aperture mode
    wire [9:0] cap = ctrl[`MTS_C_AP10] ? `MTS_BUF_WORDS : `MTS_BUF_HALF;
    wire       fn_ac_change = (fn_prev != fn) &&
                              ((fn_prev == `MTS_FN_ACV) || (fn == `MTS_FN_ACV));
    // zero-offset mode, force_ofs or oc_en decides whether an offset step costs time
    wire       need_ofs = (zo_mode == `MTS_ZO_ON) ||
                          ((zo_mode == `MTS_ZO_ONCE) && !once_valid) ||
                          force_ofs || oc_en;
    wire [15:0] raw_diff = in_val - conv_data;
    wire [15:0] once_diff = conv_data - stored_ofs;
    // Declared ahead of the clocked process that reads next_wr_ptr
    wire store = (state == ST_TRIG) && conv_done && (cv != CV_IDLE) &&
                 !((cv == CV_IN) && need_ofs) &&
                 ((fill - (pop ? 10'h001 : 10'h000)) < cap);
    wire [8:0] next_wr_ptr = store ? wr_ptr + 9'h001 : wr_ptr;

    always @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl              <= `MTS_CTRL_RST;
            trig_src          <= `MTS_TS_INT;
            trig_cnt          <= `MTS_CNT_ONE;
            samp_cnt          <= `MTS_CNT_ONE;
            state             <= ST_IDLE;
            cv                <= CV_IDLE;
            trig_done         <= 24'h000000;
            samp_done         <= 24'h000000;
            err_mem           <= 1'b0;
            ext_prev          <= 1'b1;
            once_valid        <= 1'b0;
            force_ofs         <= 1'b0;
            fn_prev           <= `MTS_FN_DCV;
            in_val            <= 16'h0000;
            stored_ofs        <= 16'h0000;
            wr_ptr            <= 9'h000;
            rd_ptr            <= 9'h000;
            fill              <= 10'h000;
            overflow          <= 1'b0;
            conv_start        <= 1'b0;
            conv_offset_step  <= 1'b0;
            current_source_on <= 1'b0;
            busy              <= 1'b0;
            scan_advance      <= 1'b0;
            rdata             <= 16'h0000;
        end else begin
            ext_prev     <= ext_trig_in;
            conv_start   <= 1'b0;
            scan_advance <= 1'b0;
            fn_prev      <= fn;
            // offset conversion owed after AC function change
            if (fn_ac_change && (zo_mode != `MTS_ZO_OFF)) begin
                force_ofs <= 1'b1;
            end
            // range_change deliberately touches no offset state
            if (state == ST_IDLE && wr) begin
                case (addr)
                    `MTS_A_CTRL: begin
                        ctrl <= wdata[10:0];
                        once_valid <= 1'b0;
                    end
                    `MTS_A_TRIGSRC: trig_src <= wdata[2:0];
                    `MTS_A_TRIGCNT: begin
                        trig_cnt <= (wdata == 16'h0000) ? `MTS_CNT_ONE : {8'h00, wdata};
                    end
                    `MTS_A_SAMPCNT: begin
                        samp_cnt <= (wdata == 16'h0000) ? `MTS_CNT_ONE : {8'h00, wdata};
                    end
                    // Upper count byte; all ones over an all-ones lower half gives the 24-bit maximum
                    `MTS_A_FILL: begin
                        trig_cnt[23:16] <= wdata[7:0];
                        samp_cnt[23:16] <= wdata[15:8];
                    end
                    default: ;
                endcase
            end
            if (conf && state == ST_IDLE) begin
                ctrl[`MTS_C_ZO_HI:`MTS_C_ZO_LO] <= `MTS_ZO_ON;
                ctrl[`MTS_C_OC] <= 1'b0;
                trig_src <= `MTS_TS_INT;
                trig_cnt <= `MTS_CNT_ONE;
                samp_cnt <= `MTS_CNT_ONE;
                once_valid <= 1'b0;
            end
            // maximum count flags out of memory, buffer still readable
            if ((trig_cnt == `MTS_CNT_MAX) || (samp_cnt == `MTS_CNT_MAX)) begin
                err_mem <= 1'b1;
            end else if (cmd_wr && wdata[`MTS_CMD_ERRCLR]) begin
                err_mem <= 1'b0;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 9'h001;
            end
            rdata <= 16'h0000;
            if (rd) begin
                case (addr)
                    `MTS_A_CTRL:    rdata <= {5'h00, ctrl};
                    `MTS_A_TRIGSRC: rdata <= {13'h0000, trig_src};
                    `MTS_A_TRIGCNT: rdata <= trig_cnt[15:0];
                    `MTS_A_SAMPCNT: rdata <= samp_cnt[15:0];
                    `MTS_A_STATUS:  rdata <= {11'h000, overflow, once_valid, err_mem, state};
                    `MTS_A_DATA:    rdata <= buf_mem[rd_ptr];
                    `MTS_A_FILL:    rdata <= {trig_cnt[23:16], samp_cnt[23:16]} ^
                                             16'h0000;
                    `MTS_A_OFFSET:  rdata <= {6'h00, fill};
                    default:        rdata <= 16'h0000;
                endcase
            end
            case (state)
                ST_IDLE: begin
                    busy <= 1'b0;
                    if (cmd_wr && wdata[`MTS_CMD_ARM]) begin
                        state     <= ST_WAIT;
                        trig_done <= 24'h000000;
                        busy      <= 1'b1;
                    end
                end
                ST_WAIT: begin
                    if (cmd_wr && wdata[`MTS_CMD_ABORT]) begin
                        state <= ST_IDLE;
                    end else if (trig_hit) begin
                        state     <= ST_TRIG;
                        samp_done <= 24'h000000;
                        cv        <= CV_IDLE;
                    end
                end
                ST_TRIG: begin
                    case (cv)
                        CV_IDLE: begin
                            // current source on for the input step of a resistance (MTS_FN_RES) measurement only
                            current_source_on <= (fn == `MTS_FN_RES);
                            conv_offset_step  <= `MTS_STEP_INPUT;
                            conv_start        <= 1'b1;
                            cv                <= CV_IN;
                        end
                        CV_IN: if (conv_done) begin
                            in_val <= conv_data;
                            if (need_ofs) begin
                                current_source_on <= 1'b0;
                                conv_offset_step  <= `MTS_STEP_OFFSET;
                                conv_start        <= 1'b1;
                                cv                <= CV_OFS;
                            end else begin
                                // No offset step: do not leave current flowing
                                current_source_on <= 1'b0;
                                cv                <= CV_IDLE;
                            end
                        end
                        CV_OFS: if (conv_done) begin
                            force_ofs <= 1'b0;
                            cv        <= CV_IDLE;
                            if (zo_mode == `MTS_ZO_ONCE && !once_valid) begin
                                stored_ofs <= conv_data;
                                once_valid <= 1'b1;
                            end
                        end
                        default: cv <= CV_IDLE;
                    endcase
                    if (cv != CV_IDLE && conv_done &&
                        !(cv == CV_IN && need_ofs)) begin
                        samp_done <= samp_done + 24'h000001;
                        if (samp_done + 24'h000001 >= samp_cnt) begin
                            // one pass per trigger when scanning
                            scan_advance <= ctrl[`MTS_C_SCAN];
                            trig_done    <= trig_done + 24'h000001;
                            // back to idle after all triggers
                            if (trig_done + 24'h000001 >= trig_cnt) begin
                                state <= ST_IDLE;
                            end else begin
                                state <= ST_WAIT;
                            end
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
            // Clear first so a drop in the same cycle still sets overflow
            if (cmd_wr && wdata[`MTS_CMD_ERRCLR]) begin
                overflow <= 1'b0;
            end
            // store reading, bounded by aperture-dependent capacity
            if (state == ST_TRIG && conv_done && cv != CV_IDLE &&
                !(cv == CV_IN && need_ofs)) begin
                if (fill - (pop ? 10'h001 : 10'h000) < cap) begin
                    wr_ptr <= wr_ptr + 9'h001;
                end else begin
                    overflow <= 1'b1;
                end
            end
            fill <= fill + ((wr_ptr != next_wr_ptr) ? 10'h001 : 10'h000) -
                    (pop ? 10'h001 : 10'h000);
        end
    end

    // Reading produced by the current conversion
    reg [15:0] reading;
    always @* begin
        if (cv == CV_OFS) begin
            // compensation result wins; same difference path
            reading = raw_diff;
        end else if (zo_mode == `MTS_ZO_ONCE && once_valid && !oc_en) begin
            reading = once_diff;
        end else begin
            reading = conv_data;
        end
    end

    always @(posedge ref_clk) begin
        if (store) begin
            buf_mem[wr_ptr] <= reading;
        end
    end
endmodule
`default_nettype wire
